/* File: tsc_defines.svh */
// Opcodes, register defaults, field positions and timing counts of the touch sensor logic.
`ifndef TSC_DEFINES_SVH
`define TSC_DEFINES_SVH
`define TSC_OP_RESET 8'h00
`define TSC_OP_CLR_INT 8'h03
`define TSC_OP_SLEEP 8'h05
`define TSC_OP_WAKE 8'h06
`define TSC_OP_WR_CFG 8'h30
`define TSC_OP_RD_CFG 8'h33
`define TSC_OP_WR_CLK 8'h35
`define TSC_OP_RD_CLK 8'h36
`define TSC_OP_WR_MSK 8'h39
`define TSC_OP_RD_MSK 8'h3a
`define TSC_OP_BUS_INT 8'h3c
`define TSC_ADDR_HI 6'h1d
`define TSC_CFG_RST 8'h00
`define TSC_CLK_RST 8'h0c
`define TSC_MSK_RST 8'hff
`define TSC_STAT_RST 8'h00
`define TSC_CFG_CASC_MSB 7
`define TSC_CFG_CASC_LSB 6
`define TSC_CFG_VREG_OFF 2
`define TSC_CFG_PRESS_INT 1
`define TSC_CASC_SECONDARY 2'h1
`define TSC_CASC_PRIMARY 2'h2
`define TSC_UP_THRESH 7'h40
`define TSC_DN_THRESH 7'h10
`define TSC_CNT_MAX 7'h7f
`define TSC_CLK_MHZ 25
`define TSC_FAST_START_US 100
`define TSC_FAST_START_CYC (`TSC_FAST_START_US * `TSC_CLK_MHZ)
`define TSC_SLOT_CYC 6'h3f
`define TSC_MEAS_CYC 6'h28
`endif

/* File: tsc_pkg.sv */
// Types shared by the touch sensor logic.
package tsc_pkg;
  typedef enum logic [8:0] {
    TSC_I2C_IDLE = 9'h001,
    TSC_I2C_ADDR = 9'h002,
    TSC_I2C_ADDR_ACK = 9'h004,
    TSC_I2C_CMD = 9'h008,
    TSC_I2C_CMD_ACK = 9'h010,
    TSC_I2C_DATA = 9'h020,
    TSC_I2C_DATA_ACK = 9'h040,
    TSC_I2C_RD = 9'h080,
    TSC_I2C_RD_ACK = 9'h100
  } tsc_i2c_state_t;
  typedef enum logic [2:0] {
    TSC_SL_WAIT = 3'h1,
    TSC_SL_MEAS = 3'h2,
    TSC_SL_DONE = 3'h4
  } tsc_slot_state_t;
endpackage

/* File: tsc_top.sv */
// Touch sensor channel logic and I2C command interpreter.
`timescale 1ns/100ps
`include "tsc_defines.svh"
// What this block does
// - Sample the eight channels in turn, activating the reference element each time.
// - Up pulse when reference comparator switches first, down pulse when sensor does.
// - Per-channel counter counts same-direction pulses, restarted at 1 on direction change.
// - Channel output activates only after 64 consecutive up pulses.
// - Sensor-state register holds channel outputs ANDed with the mask register; any change raises the interrupt, only a new press when config bit 1 is set.
// - Sampling rate comes from the oscillator, trimmed by the clock setting register.
// - Soft reset opcode restores channel logic and registers, leaves bus-interrupt mode.
// - Interrupt-clear opcode, no data byte, releases the interrupt pin.
// - Sleep and wake opcodes; the sleep pin high also puts the device asleep.
// - Opcodes write and read the configuration register, one byte each.
// - Opcodes write and read the clock setting register, one byte each.
// - Opcodes write and read the channel mask register, one byte each.
// - Clock and mask change only by their write opcodes or soft reset; some commands need no data.
// - Bus-interrupt opcode, no data byte, enters interrupt-over-I2C mode.
// - Read bit set in the address means sensor-state read, which clears interrupt.
// - Each further read byte of that transaction returns the sensor state again.
// - Cascaded devices take turns returning their sensor state within one read.
// - Sleep stops oscillator, analog and regulator, keeps registers, still answers I2C.
// - Leaving sleep runs the full start-up including reservoir fast-start charging.
// - Sleep by command ends only by wake or soft reset command; the pin has no effect on it.
// - Sleep by pin ends only when the pin goes low; wake command is ignored.
// - Reset only at power-on or by soft reset command.
// - Address select pin gives the slave address LSB.
module tsc_top (
  // Clocks and power-on reset
  input wire logic ref_clk_i,
  input wire logic osc_clk_i,
  input wire logic nrst_i,
  // I2C pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Device pins
  input wire logic address_select_pin_i,
  input wire logic sleep_pin_i,
  output logic int_n_o,
  // Analog front end, oscillator domain
  input wire logic ref_cmp_i,
  input wire logic [7:0] sensor_inputs_i,
  output logic ref_act_o,
  output logic [7:0] ch_sel_o,
  output logic [7:0] up_pulse_o,
  output logic [7:0] down_pulse_o,
  // Analog control and state, reference domain
  output logic osc_en_o,
  output logic vreg_en_o,
  output logic fast_start_o,
  output logic bus_int_mode_o,
  output logic [7:0] clock_setting_o,
  output logic [7:0] config_o,
  output logic [7:0] sensor_state_o
);

  function automatic logic [7:0] tsc_onehot(input logic [2:0] idx);
    tsc_onehot = 8'h01 << idx;
  endfunction

  function automatic logic tsc_own_turn(input logic stat_rd, input logic [1:0] casc,
                                        input logic byte_odd);
    tsc_own_turn = ~stat_rd
                 | ((casc != `TSC_CASC_SECONDARY) && (casc != `TSC_CASC_PRIMARY))
                 | (byte_odd == (casc == `TSC_CASC_SECONDARY));
  endfunction

  // Reference domain: pin synchronisers.
  logic [1:0] scl_s, sda_s, asel_s, slp_s;
  logic scl_d, sda_d;
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      asel_s <= 2'h0;
      slp_s <= 2'h0;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_s <= {scl_s[0], scl_i};
      sda_s <= {sda_s[0], sda_i};
      asel_s <= {asel_s[0], address_select_pin_i};
      slp_s <= {slp_s[0], sleep_pin_i};
      scl_d <= scl_s[1];
      sda_d <= sda_s[1];
    end
  end

  wire scl_rise = scl_s[1] & ~scl_d;
  wire scl_fall = ~scl_s[1] & scl_d;
  wire i2c_start = scl_s[1] & scl_d & sda_d & ~sda_s[1];
  wire i2c_stop = scl_s[1] & scl_d & ~sda_d & sda_s[1];

  tsc_pkg::tsc_i2c_state_t st_reg, st_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] shift_reg, shift_next, tx_reg, tx_next, op_reg, op_next;
  logic oe_reg, oe_next, byte_reg, byte_next, stat_rd_reg, stat_rd_next;
  logic [7:0] cfg_reg, clk_reg, msk_reg, sensor_state_reg;
  logic int_pend_reg, bus_int_reg, asleep_reg, by_cmd_reg;
  logic asleep_next, by_cmd_next;
  logic [11:0] fs_cnt_reg;
  logic rst_tog_reg;
  logic [1:0] req_s;
  logic req_d;
  logic [7:0] hold_reg;
  logic req_tog_reg;

  wire bit8 = (bit_reg == 4'h8);
  wire [1:0] casc = cfg_reg[`TSC_CFG_CASC_MSB:`TSC_CFG_CASC_LSB];
  wire addr_hit = (shift_reg[7:1] == {`TSC_ADDR_HI, asel_s[1]});
  wire cmd_go = scl_fall & (st_reg == tsc_pkg::TSC_I2C_CMD) & bit8;
  wire data_go = scl_fall & (st_reg == tsc_pkg::TSC_I2C_DATA) & bit8;
  wire stat_rd_go = scl_fall & (st_reg == tsc_pkg::TSC_I2C_ADDR_ACK) & shift_reg[0];
  wire op_wr = (op_reg == `TSC_OP_WR_CFG) | (op_reg == `TSC_OP_WR_CLK)
             | (op_reg == `TSC_OP_WR_MSK);
  wire op_rd = (op_reg == `TSC_OP_RD_CFG) | (op_reg == `TSC_OP_RD_CLK)
             | (op_reg == `TSC_OP_RD_MSK);
  wire [7:0] rd_src = (op_reg == `TSC_OP_RD_CFG) ? cfg_reg :
                      (op_reg == `TSC_OP_RD_CLK) ? clk_reg : msk_reg;
  wire turn_now = tsc_own_turn(stat_rd_reg, casc, byte_reg);
  wire turn_nx = tsc_own_turn(1'b1, casc, ~byte_reg);

  // I2C bit and byte sequencing.
  always_comb begin
    st_next = st_reg;
    bit_next = bit_reg;
    shift_next = shift_reg;
    tx_next = tx_reg;
    oe_next = oe_reg;
    byte_next = byte_reg;
    op_next = op_reg;
    stat_rd_next = stat_rd_reg;
    if (i2c_stop) begin
      st_next = tsc_pkg::TSC_I2C_IDLE;
      oe_next = 1'b0;
    end else if (i2c_start) begin
      st_next = tsc_pkg::TSC_I2C_ADDR;
      bit_next = 4'h0;
      oe_next = 1'b0;
    end else if (scl_rise) begin
      case (st_reg)
        tsc_pkg::TSC_I2C_ADDR, tsc_pkg::TSC_I2C_CMD, tsc_pkg::TSC_I2C_DATA: begin
          shift_next = {shift_reg[6:0], sda_s[1]};
          bit_next = bit_reg + 4'h1;
        end
        tsc_pkg::TSC_I2C_RD_ACK: begin
          if (sda_s[1]) begin
            st_next = tsc_pkg::TSC_I2C_IDLE;
          end
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (st_reg)
        tsc_pkg::TSC_I2C_ADDR: begin
          if (bit8) begin
            st_next = addr_hit ? tsc_pkg::TSC_I2C_ADDR_ACK : tsc_pkg::TSC_I2C_IDLE;
            oe_next = addr_hit;
          end
        end
        tsc_pkg::TSC_I2C_CMD: begin
          if (bit8) begin
            st_next = tsc_pkg::TSC_I2C_CMD_ACK;
            oe_next = 1'b1;
            op_next = shift_reg;
          end
        end
        tsc_pkg::TSC_I2C_DATA: begin
          if (bit8) begin
            st_next = tsc_pkg::TSC_I2C_DATA_ACK;
            oe_next = 1'b1;
          end
        end
        tsc_pkg::TSC_I2C_ADDR_ACK: begin
          bit_next = 4'h0;
          oe_next = 1'b0;
          st_next = tsc_pkg::TSC_I2C_CMD;
          if (shift_reg[0]) begin
            st_next = tsc_pkg::TSC_I2C_RD;
            tx_next = sensor_state_reg;
            byte_next = 1'b0;
            stat_rd_next = 1'b1;
            bit_next = 4'h1;
            oe_next = tsc_own_turn(1'b1, casc, 1'b0) & ~sensor_state_reg[7];
          end
        end
        tsc_pkg::TSC_I2C_CMD_ACK: begin
          bit_next = 4'h0;
          oe_next = 1'b0;
          st_next = op_wr ? tsc_pkg::TSC_I2C_DATA : tsc_pkg::TSC_I2C_IDLE;
          if (op_rd) begin
            st_next = tsc_pkg::TSC_I2C_RD;
            tx_next = rd_src;
            stat_rd_next = 1'b0;
            byte_next = 1'b0;
            bit_next = 4'h1;
            oe_next = ~rd_src[7];
          end
        end
        tsc_pkg::TSC_I2C_RD: begin
          if (bit8) begin
            st_next = tsc_pkg::TSC_I2C_RD_ACK;
            oe_next = 1'b0;
          end else begin
            oe_next = turn_now & ~tx_reg[6];
            tx_next = {tx_reg[6:0], 1'b0};
            bit_next = bit_reg + 4'h1;
          end
        end
        tsc_pkg::TSC_I2C_RD_ACK: begin
          st_next = tsc_pkg::TSC_I2C_IDLE;
          if (stat_rd_reg) begin
            st_next = tsc_pkg::TSC_I2C_RD;
            tx_next = sensor_state_reg;
            byte_next = ~byte_reg;
            bit_next = 4'h1;
            oe_next = turn_nx & ~sensor_state_reg[7];
          end
        end
        default: begin
          st_next = tsc_pkg::TSC_I2C_IDLE;
          oe_next = 1'b0;
        end
      endcase
    end
  end

  // Command decoding; unmatched opcodes hit none of these strobes.
  wire soft_rst = cmd_go & (shift_reg == `TSC_OP_RESET);
  wire clr_cmd = cmd_go & (shift_reg == `TSC_OP_CLR_INT);
  wire slp_cmd = cmd_go & (shift_reg == `TSC_OP_SLEEP);
  wire wake_cmd = cmd_go & (shift_reg == `TSC_OP_WAKE);
  wire busint_cmd = cmd_go & (shift_reg == `TSC_OP_BUS_INT);
  wire [7:0] cfg_next = soft_rst ? `TSC_CFG_RST :
    (data_go && op_reg == `TSC_OP_WR_CFG) ? shift_reg : cfg_reg;
  wire [7:0] clk_next = soft_rst ? `TSC_CLK_RST :
    (data_go && op_reg == `TSC_OP_WR_CLK) ? shift_reg : clk_reg;
  wire [7:0] msk_next = soft_rst ? `TSC_MSK_RST :
    (data_go && op_reg == `TSC_OP_WR_MSK) ? shift_reg : msk_reg;
  wire bus_int_next = ~soft_rst & (bus_int_reg | busint_cmd);

  // Sensor state capture from the oscillator domain and interrupt.
  wire new_word = req_s[1] ^ req_d;
  wire [7:0] cap = hold_reg & msk_reg;
  wire [7:0] stat_next = soft_rst ? `TSC_STAT_RST : new_word ? cap : sensor_state_reg;
  wire [7:0] stat_diff = cfg_reg[`TSC_CFG_PRESS_INT] ? (cap & ~sensor_state_reg)
                                                     : (cap ^ sensor_state_reg);
  wire int_ev = new_word & ~soft_rst & (|stat_diff);
  wire int_clr = clr_cmd | stat_rd_go | soft_rst;
  wire int_next = int_ev | (int_pend_reg & ~int_clr);

  // Sleep sources stay independent of each other.
  always_comb begin
    asleep_next = asleep_reg;
    by_cmd_next = by_cmd_reg;
    if (!asleep_reg) begin
      if (slp_s[1]) begin
        asleep_next = 1'b1;
        by_cmd_next = 1'b0;
      end else if (slp_cmd) begin
        asleep_next = 1'b1;
        by_cmd_next = 1'b1;
      end
    end else if (by_cmd_reg) begin
      if (wake_cmd || soft_rst) begin
        asleep_next = 1'b0;
        by_cmd_next = 1'b0;
      end
    end else if (!slp_s[1]) begin
      asleep_next = 1'b0;
    end
  end

  wire woke = asleep_reg & ~asleep_next;
  wire [11:0] fs_next = woke ? 12'(`TSC_FAST_START_CYC) :
    (fs_cnt_reg != 12'h000) ? fs_cnt_reg - 12'h001 : 12'h000;

  // Power-on reset is the only hardware reset.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg <= tsc_pkg::TSC_I2C_IDLE;
      bit_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      op_reg <= 8'h00;
      oe_reg <= 1'b0;
      byte_reg <= 1'b0;
      stat_rd_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      bit_reg <= bit_next;
      shift_reg <= shift_next;
      tx_reg <= tx_next;
      op_reg <= op_next;
      oe_reg <= oe_next;
      byte_reg <= byte_next;
      stat_rd_reg <= stat_rd_next;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_reg <= `TSC_CFG_RST;
      clk_reg <= `TSC_CLK_RST;
      msk_reg <= `TSC_MSK_RST;
      sensor_state_reg <= `TSC_STAT_RST;
      int_pend_reg <= 1'b0;
      bus_int_reg <= 1'b0;
      asleep_reg <= 1'b0;
      by_cmd_reg <= 1'b0;
      fs_cnt_reg <= 12'(`TSC_FAST_START_CYC);
      rst_tog_reg <= 1'b0;
      req_s <= 2'h0;
      req_d <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      clk_reg <= clk_next;
      msk_reg <= msk_next;
      sensor_state_reg <= stat_next;
      int_pend_reg <= int_next;
      bus_int_reg <= bus_int_next;
      asleep_reg <= asleep_next;
      by_cmd_reg <= by_cmd_next;
      fs_cnt_reg <= fs_next;
      rst_tog_reg <= rst_tog_reg ^ soft_rst;
      req_s <= {req_s[0], req_tog_reg};
      req_d <= req_s[1];
    end
  end

  // Registered outputs of the reference domain.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
      int_n_o <= 1'b1;
      osc_en_o <= 1'b1;
      vreg_en_o <= 1'b1;
      fast_start_o <= 1'b1;
      bus_int_mode_o <= 1'b0;
      clock_setting_o <= `TSC_CLK_RST;
      config_o <= `TSC_CFG_RST;
      sensor_state_o <= `TSC_STAT_RST;
    end else begin
      sda_o <= 1'b0;
      sda_oe_o <= oe_next;
      int_n_o <= ~(int_next & ~bus_int_next);
      osc_en_o <= ~asleep_next;
      vreg_en_o <= ~asleep_next & ~cfg_next[`TSC_CFG_VREG_OFF];
      fast_start_o <= (fs_next != 12'h000);
      bus_int_mode_o <= bus_int_next;
      clock_setting_o <= clk_next;
      config_o <= cfg_next;
      sensor_state_o <= stat_next;
    end
  end

  // Oscillator domain: synchronisers for comparators and control crossings.
  logic [1:0] rcmp_s, rst_s, ack_s, osl_s;
  logic [7:0] scmp_s0, scmp_s1;
  logic rst_d;
  always_ff @(posedge osc_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rcmp_s <= 2'h3;
      scmp_s0 <= 8'hff;
      scmp_s1 <= 8'hff;
      rst_s <= 2'h0;
      rst_d <= 1'b0;
      ack_s <= 2'h0;
      osl_s <= 2'h0;
    end else begin
      rcmp_s <= {rcmp_s[0], ref_cmp_i};
      scmp_s0 <= sensor_inputs_i;
      scmp_s1 <= scmp_s0;
      rst_s <= {rst_s[0], rst_tog_reg};
      rst_d <= rst_s[1];
      ack_s <= {ack_s[0], req_d};
      osl_s <= {osl_s[0], asleep_reg};
    end
  end

  wire osc_srst = rst_s[1] ^ rst_d;
  tsc_pkg::tsc_slot_state_t sl_reg, sl_next;
  logic [2:0] ch_reg;
  logic [5:0] tim_reg;
  wire ref_low = ~rcmp_s[1];
  wire sen_low = ~scmp_s1[ch_reg];
  wire in_meas = (sl_reg == tsc_pkg::TSC_SL_MEAS);
  wire up_now = in_meas & ref_low & ~sen_low;
  wire dn_now = in_meas & sen_low & ~ref_low;
  wire [7:0] up_vec = up_now ? tsc_onehot(ch_reg) : 8'h00;
  wire [7:0] dn_vec = dn_now ? tsc_onehot(ch_reg) : 8'h00;

  always_comb begin
    case (sl_reg)
      tsc_pkg::TSC_SL_WAIT:
        sl_next = (!osl_s[1] && tim_reg == `TSC_SLOT_CYC) ? tsc_pkg::TSC_SL_MEAS : sl_reg;
      tsc_pkg::TSC_SL_MEAS:
        sl_next = (up_now || dn_now || tim_reg == `TSC_MEAS_CYC) ? tsc_pkg::TSC_SL_DONE
                                                                 : sl_reg;
      default:
        sl_next = tsc_pkg::TSC_SL_WAIT;
    endcase
  end

  wire [5:0] tim_next = (sl_next != sl_reg) ? 6'h00 : tim_reg + 6'h01;
  wire [2:0] ch_next = (sl_reg == tsc_pkg::TSC_SL_DONE) ? ch_reg + 3'h1 : ch_reg;

  always_ff @(posedge osc_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sl_reg <= tsc_pkg::TSC_SL_WAIT;
      ch_reg <= 3'h0;
      tim_reg <= 6'h00;
      ref_act_o <= 1'b0;
      ch_sel_o <= 8'h00;
      up_pulse_o <= 8'h00;
      down_pulse_o <= 8'h00;
    end else if (osc_srst) begin
      sl_reg <= tsc_pkg::TSC_SL_WAIT;
      ch_reg <= 3'h0;
      tim_reg <= 6'h00;
      ref_act_o <= 1'b0;
      ch_sel_o <= 8'h00;
      up_pulse_o <= 8'h00;
      down_pulse_o <= 8'h00;
    end else begin
      sl_reg <= sl_next;
      ch_reg <= ch_next;
      tim_reg <= tim_next;
      ref_act_o <= (sl_next == tsc_pkg::TSC_SL_MEAS);
      ch_sel_o <= (sl_next == tsc_pkg::TSC_SL_MEAS) ? tsc_onehot(ch_next) : 8'h00;
      up_pulse_o <= up_vec;
      down_pulse_o <= dn_vec;
    end
  end

  // Per-channel run counters and channel outputs.
  wire [7:0] channel_outputs_w;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : gen_ch
      logic [6:0] cnt_reg;
      logic dir_reg, out_reg;
      wire hit = up_vec[g] | dn_vec[g];
      wire [6:0] cnt_inc = (cnt_reg == `TSC_CNT_MAX) ? cnt_reg : cnt_reg + 7'h01;
      wire [6:0] cnt_next = !hit ? cnt_reg : (dir_reg == up_vec[g]) ? cnt_inc : 7'h01;
      wire on_set = up_vec[g] & (cnt_next >= `TSC_UP_THRESH);
      wire on_clr = dn_vec[g] & (cnt_next >= `TSC_DN_THRESH);
      always_ff @(posedge osc_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          cnt_reg <= 7'h00;
          dir_reg <= 1'b0;
          out_reg <= 1'b0;
        end else if (osc_srst) begin
          cnt_reg <= 7'h00;
          dir_reg <= 1'b0;
          out_reg <= 1'b0;
        end else begin
          cnt_reg <= cnt_next;
          dir_reg <= hit ? up_vec[g] : dir_reg;
          out_reg <= on_set | (out_reg & ~on_clr);
        end
      end
      assign channel_outputs_w[g] = out_reg;
    end
  endgenerate

  // Toggle handshake carries each new channel word to the reference domain.
  wire hs_busy = req_tog_reg ^ ack_s[1];
  wire hs_send = ~hs_busy & (channel_outputs_w != hold_reg);
  always_ff @(posedge osc_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hold_reg <= 8'h00;
      req_tog_reg <= 1'b0;
    end else begin
      hold_reg <= hs_send ? channel_outputs_w : hold_reg;
      req_tog_reg <= req_tog_reg ^ hs_send;
    end
  end

endmodule // tsc_top

/* File: tsc_top_properties.sv */
// Port-level assertions for the touch sensor logic.
`timescale 1ns/100ps
module tsc_checker (
  // Clocks and reset
  input wire logic ref_clk_i,
  input wire logic osc_clk_i,
  input wire logic nrst_i,
  // Device side
  input wire logic sleep_pin_i,
  input wire logic int_n_o,
  input wire logic osc_en_o,
  input wire logic vreg_en_o,
  input wire logic fast_start_o,
  input wire logic bus_int_mode_o,
  input wire logic [7:0] sensor_state_o,
  // Channel side
  input wire logic ref_act_o,
  input wire logic [7:0] ch_sel_o,
  input wire logic [7:0] up_pulse_o,
  input wire logic [7:0] down_pulse_o
);
  property p_bus_int;
    @(posedge ref_clk_i) disable iff (!nrst_i) bus_int_mode_o |-> int_n_o;
  endproperty
  a_bus_int: assert property (p_bus_int) else $error("int pin low in bus mode");
  property p_set_int;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      (|(sensor_state_o & ~$past(sensor_state_o))) && !bus_int_mode_o |-> ##[0:3] !int_n_o;
  endproperty
  a_set_int: assert property (p_set_int) else $error("no interrupt on state change");
  property p_pin_sleep;
    @(posedge ref_clk_i) disable iff (!nrst_i) $rose(sleep_pin_i) |-> ##[1:8] !osc_en_o;
  endproperty
  a_pin_sleep: assert property (p_pin_sleep) else $error("sleep pin ignored");
  property p_vreg_off;
    @(posedge ref_clk_i) disable iff (!nrst_i) $fell(osc_en_o) |-> ##[0:2] !vreg_en_o;
  endproperty
  a_vreg_off: assert property (p_vreg_off) else $error("regulator on in sleep");
  property p_fast_start;
    @(posedge ref_clk_i) disable iff (!nrst_i) $rose(osc_en_o) |-> ##[0:2] fast_start_o;
  endproperty
  a_fast_start: assert property (p_fast_start) else $error("no fast start on wake");
  property p_pulse_once;
    @(posedge osc_clk_i) disable iff (!nrst_i)
      (up_pulse_o | down_pulse_o) != 8'h00 |=> (up_pulse_o | down_pulse_o) == 8'h00;
  endproperty
  a_pulse_once: assert property (p_pulse_once) else $error("pulse longer than a cycle");
  property p_up_dn;
    @(posedge osc_clk_i) disable iff (!nrst_i) (up_pulse_o & down_pulse_o) == 8'h00;
  endproperty
  a_up_dn: assert property (p_up_dn) else $error("up and down pulse together");
  property p_sel;
    @(posedge osc_clk_i) disable iff (!nrst_i) ref_act_o |-> $onehot(ch_sel_o);
  endproperty
  a_sel: assert property (p_sel) else $error("measurement without one channel");
  c_up: cover property (@(posedge osc_clk_i) up_pulse_o[0]);
  c_int: cover property (@(posedge ref_clk_i) $fell(int_n_o));
  c_sleep: cover property (@(posedge ref_clk_i) $fell(osc_en_o));
endmodule // tsc_checker
bind tsc_top tsc_checker u_chk (.ref_clk_i(ref_clk_i), .osc_clk_i(osc_clk_i), .nrst_i(nrst_i),
  .sleep_pin_i(sleep_pin_i), .int_n_o(int_n_o), .osc_en_o(osc_en_o), .vreg_en_o(vreg_en_o),
  .fast_start_o(fast_start_o), .bus_int_mode_o(bus_int_mode_o),
  .sensor_state_o(sensor_state_o), .ref_act_o(ref_act_o), .ch_sel_o(ch_sel_o),
  .up_pulse_o(up_pulse_o), .down_pulse_o(down_pulse_o));

/* File: tsc_afe_model.sv */
// Oscillator and comparator model of the analog front end.
`timescale 1ns/100ps
module tsc_afe_model (
  // Oscillator
  input wire logic osc_en_i,
  output logic osc_clk_o,
  // Comparators
  input wire logic ref_act_i,
  input wire logic [7:0] ch_sel_i,
  input wire logic [7:0] touch_i,
  output logic ref_cmp_o,
  output logic [7:0] sensor_inputs_o
);
  logic [5:0] t_reg = 6'h00;
  wire [5:0] thr = (|(ch_sel_i & touch_i)) ? 6'h14 : 6'h04;
  initial osc_clk_o = 1'b0;
  // The oscillator stops while the device is asleep.
  always begin
    #15;
    osc_clk_o = (osc_en_i === 1'b1) ? ~osc_clk_o : 1'b0;
  end
  always @(posedge osc_clk_o) t_reg <= ref_act_i ? t_reg + 6'h01 : 6'h00;
  // A touched plate discharges slower than the reference, an idle one faster.
  assign ref_cmp_o = !(ref_act_i && t_reg >= 6'h0a);
  assign sensor_inputs_o = ~((ref_act_i && t_reg >= thr) ? ch_sel_i : 8'h00);
endmodule // tsc_afe_model

/* File: tsc_top_tb.sv */
// Self-checking testbench of the touch sensor logic.
`timescale 1ns/100ps
`include "tsc_defines.svh"
module tsc_top_tb;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic scl = 1'b1;
  logic sda_h = 1'b1;
  logic asel = 1'b0;
  logic slp = 1'b0;
  logic [7:0] touch = 8'h00;
  logic osc_clk, ref_cmp, sda_o, sda_oe, int_n, ref_act, osc_en, vreg_en, fast_st, bus_int;
  logic [7:0] cmp_in, ch_sel, up, dn, clk_set, cfg, stat, q;
  logic [8:0] rx;
  wire sda_w = (sda_oe ? sda_o : 1'b1) & sda_h;
  int err_total = 0;
  int tests_run = 0;
  int ups = 0;
  logic [7:0] rop [3] = '{`TSC_OP_RD_CFG, `TSC_OP_RD_CLK, `TSC_OP_RD_MSK};
  logic [7:0] wop [3] = '{`TSC_OP_WR_CFG, `TSC_OP_WR_CLK, `TSC_OP_WR_MSK};
  logic [7:0] dflt [3] = '{`TSC_CFG_RST, `TSC_CLK_RST, `TSC_MSK_RST};
  logic [7:0] wval [3] = '{8'h01, 8'h0a, 8'h5a};
  always #20 ref_clk_i = ~ref_clk_i;
  always @(posedge osc_clk) if (up[0]) ups <= ups + 1;
  tsc_afe_model afe (.osc_en_i(osc_en), .osc_clk_o(osc_clk), .ref_act_i(ref_act),
    .ch_sel_i(ch_sel), .touch_i(touch), .ref_cmp_o(ref_cmp), .sensor_inputs_o(cmp_in));
  tsc_top uut (.ref_clk_i(ref_clk_i), .osc_clk_i(osc_clk), .nrst_i(nrst_i), .scl_i(scl),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe), .address_select_pin_i(asel),
    .sleep_pin_i(slp), .int_n_o(int_n), .ref_cmp_i(ref_cmp), .sensor_inputs_i(cmp_in),
    .ref_act_o(ref_act), .ch_sel_o(ch_sel), .up_pulse_o(up), .down_pulse_o(dn),
    .osc_en_o(osc_en), .vreg_en_o(vreg_en), .fast_start_o(fast_st), .bus_int_mode_o(bus_int),
    .clock_setting_o(clk_set), .config_o(cfg), .sensor_state_o(stat));
  task tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task bit9(input logic [8:0] tx);
    for (int i = 8; i >= 0; i--) begin
      sda_h = tx[i];
      tick(6);
      scl = 1'b1;
      tick(6);
      rx[i] = sda_w;
      scl = 1'b0;
      tick(2);
    end
  endtask
  task sta();
    sda_h = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(6);
    sda_h = 1'b0;
    tick(6);
    scl = 1'b0;
    tick(2);
  endtask
  task sto();
    sda_h = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(6);
    sda_h = 1'b1;
    tick(6);
  endtask
  task adr(input logic rw);
    bit9({`TSC_ADDR_HI, asel, rw, 1'b1});
    chk("addr_ack", {7'h00, rx[0]}, 8'h00);
  endtask
  task xact(input logic [7:0] op, input int kind, input logic [7:0] d);
    sta();
    adr(1'b0);
    bit9({op, 1'b1});
    if (kind == 1) bit9({d, 1'b1});
    if (kind == 2) bit9(9'h1ff);
    q = rx[8:1];
    sto();
  endtask
  task sread(input logic [7:0] e, input logic [7:0] e1);
    sta();
    adr(1'b1);
    bit9({8'hff, 1'b0});
    chk("stat_rd0", rx[8:1], e);
    bit9(9'h1ff);
    chk("stat_rd1", rx[8:1], e1);
    sto();
  endtask
  task regs(input logic wr);
    for (int i = 0; i < 3; i++) begin
      xact(rop[i], 2, 8'h00);
      chk("reg", q, wr ? wval[i] : dflt[i]);
    end
  endtask
  task wstat(input logic e);
    int n;
    n = 0;
    while (stat[0] !== e && n < 60000) begin
      tick(1);
      n++;
    end
  endtask
  task stop_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    tick(16);
    nrst_i = 1'b1;
    tick(5);
    regs(1'b0);
    for (int i = 0; i < 3; i++) xact(wop[i], 1, wval[i]);
    regs(1'b1);
    chk("clk_set", clk_set, 8'h0a);
    chk("cfg", cfg, 8'h01);
    xact(8'h31, 0, 8'h00);
    regs(1'b1);
    xact(`TSC_OP_BUS_INT, 0, 8'h00);
    chk("bus_int", {7'h00, bus_int}, 8'h01);
    xact(`TSC_OP_RESET, 0, 8'h00);
    regs(1'b0);
    chk("bus_int", {7'h00, bus_int}, 8'h00);
    $display("register tests done");
    touch = 8'h01;
    ups = 0;
    wstat(1'b1);
    chk("ups", {7'h00, ups >= 64 && ups <= 65}, 8'h01);
    chk("int", {7'h00, int_n}, 8'h00);
    xact(`TSC_OP_CLR_INT, 0, 8'h00);
    chk("int", {7'h00, int_n}, 8'h01);
    sread(8'h01, 8'h01);
    touch = 8'h00;
    wstat(1'b0);
    chk("stat", stat, 8'h00);
    chk("int", {7'h00, int_n}, 8'h00);
    sread(8'h00, 8'h00);
    chk("int", {7'h00, int_n}, 8'h01);
    $display("channel tests done");
    xact(`TSC_OP_WR_CFG, 1, 8'h80);
    sread(8'h00, 8'hff);
    xact(`TSC_OP_WR_CFG, 1, 8'h40);
    sread(8'hff, 8'h00);
    $display("cascade tests done");
    xact(`TSC_OP_SLEEP, 0, 8'h00);
    chk("osc_en", {7'h00, osc_en}, 8'h00);
    chk("vreg", {7'h00, vreg_en}, 8'h00);
    xact(`TSC_OP_RD_MSK, 2, 8'h00);
    chk("msk_sleep", q, `TSC_MSK_RST);
    slp = 1'b1;
    tick(8);
    slp = 1'b0;
    tick(8);
    chk("osc_en", {7'h00, osc_en}, 8'h00);
    xact(`TSC_OP_WAKE, 0, 8'h00);
    chk("osc_en", {7'h00, osc_en}, 8'h01);
    chk("fast", {7'h00, fast_st}, 8'h01);
    slp = 1'b1;
    tick(8);
    chk("osc_en", {7'h00, osc_en}, 8'h00);
    xact(`TSC_OP_WAKE, 0, 8'h00);
    chk("osc_en", {7'h00, osc_en}, 8'h00);
    slp = 1'b0;
    tick(8);
    chk("osc_en", {7'h00, osc_en}, 8'h01);
    $display("sleep tests done");
    asel = 1'b1;
    tick(4);
    xact(`TSC_OP_RD_CLK, 2, 8'h00);
    chk("clk", q, `TSC_CLK_RST);
    sta();
    bit9({`TSC_ADDR_HI, 1'b0, 2'b01});
    chk("wrong_addr", {7'h00, rx[0]}, 8'h01);
    sto();
    $display("address tests done");
    stop_test();
  end
  initial begin
    #(40 * 95000);
    err_total++;
    stop_test();
  end
endmodule // tsc_top_tb
